/* File: hw/psb_defs.vh */
`ifndef PSB_DEFS_VH
`define PSB_DEFS_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PSB_INIT_US 150
`define PSB_CLK_MHZ 20
`define PSB_INIT_CYC (`PSB_INIT_US * `PSB_CLK_MHZ)
`define PSB_INIT_W 12

// ------------------------------------------------------------
// Array and pins
// ------------------------------------------------------------
`define PSB_AW 24
`define PSB_DW 16
`define PSB_AHI_W 8
`define PSB_SYNC_W 32
`define PSB_SYNC_RST 32'h0000007B

// ------------------------------------------------------------
// Configuration registers
// ------------------------------------------------------------
`define PSB_BCR_MODE 15
`define PSB_BCR_WPOL 10
`define PSB_BCR_RST 16'h8000
`define PSB_RCR_RST 16'h0000
`define PSB_ID_VAL 16'h0A5C
`define PSB_SEL_HI 19
`define PSB_SEL_LO 18
`define PSB_SEL_RCR 2'h0
`define PSB_SEL_ID 2'h1
`define PSB_SEL_BCR 2'h2

// ------------------------------------------------------------
// Software register port
// ------------------------------------------------------------
`define PSB_RA_STAT 2'h0
`define PSB_RA_BCR 2'h1
`define PSB_RA_RCR 2'h2
`define PSB_RA_LAT 2'h3
`define PSB_LAT_W 3
`define PSB_LAT_RST 3'h3
`define PSB_LAT_ONE 3'h1

`endif

/* File: hw/psb_sync.v */
`timescale 1ns/100ps
`include "psb_defs.vh"

module psb_sync #(
    parameter W = `PSB_SYNC_W,
    parameter [W-1:0] RST_VAL = `PSB_SYNC_RST
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [W-1:0] pin_i,
    output reg [W-1:0] val_o
);

// ------------------------------------------------------------
// Three stages per bit, change taken when stages two and three agree
// ------------------------------------------------------------
reg [W-1:0] ff1;
reg [W-1:0] ff2;
reg [W-1:0] ff3;

genvar i;
generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
        always @(posedge core_clk_i) begin
            if (rst_i) begin
                ff1[i] <= RST_VAL[i];
                ff2[i] <= RST_VAL[i];
                ff3[i] <= RST_VAL[i];
                val_o[i] <= RST_VAL[i];
            end else if (ce_i) begin
                ff1[i] <= pin_i[i];
                ff2[i] <= ff1[i];
                ff3[i] <= ff2[i];
                if (ff2[i] == ff3[i]) begin
                    val_o[i] <= ff3[i];
                end
            end
        end
    end
endgenerate

endmodule // psb_sync

/* File: hw/psb_cfg_regs.v */
`timescale 1ns/100ps
`include "psb_defs.vh"

module psb_cfg_regs (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire we_i,
    input wire [1:0] sel_i,
    input wire [`PSB_DW-1:0] wdata_i,
    output reg [`PSB_DW-1:0] bus_cfg_reg_o,
    output reg [`PSB_DW-1:0] refresh_cfg_reg_o,
    output reg [`PSB_DW-1:0] rdata_o
);

// ------------------------------------------------------------
// Register load, defaults at reset
// ------------------------------------------------------------
always @(posedge core_clk_i) begin
    if (rst_i) begin
        bus_cfg_reg_o <= `PSB_BCR_RST;
        refresh_cfg_reg_o <= `PSB_RCR_RST;
    end else if (ce_i && we_i) begin
        if (sel_i == `PSB_SEL_BCR) begin
            bus_cfg_reg_o <= wdata_i;
        end else if (sel_i == `PSB_SEL_RCR) begin
            refresh_cfg_reg_o <= wdata_i;
        end
    end
end

// ------------------------------------------------------------
// Read select
// ------------------------------------------------------------
always @* begin
    case (sel_i)
        `PSB_SEL_BCR: rdata_o = bus_cfg_reg_o;
        `PSB_SEL_RCR: rdata_o = refresh_cfg_reg_o;
        `PSB_SEL_ID: rdata_o = `PSB_ID_VAL;
        default: rdata_o = {`PSB_DW{1'b0}};
    endcase
end

endmodule // psb_cfg_regs

/* File: hw/psb_bus_if.v */
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "psb_defs.vh"


module psb_bus_if (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire link_clk_i,
    input wire addr_valid_n_i,
    input wire chip_sel_n_i,
    input wire out_en_n_i,
    input wire wr_en_n_i,
    input wire cfg_reg_sel_i,
    input wire low_byte_en_n_i,
    input wire high_byte_en_n_i,
    input wire [`PSB_AHI_W-1:0] addr_hi_i,
    input wire [`PSB_DW-1:0] ad_i,
    output reg [`PSB_DW-1:0] ad_o,
    output reg [`PSB_DW-1:0] ad_oe_o,
    output reg wait_o,
    output reg wait_oe_o,
    output reg [`PSB_AW-1:0] mem_addr_o,
    output reg [`PSB_DW-1:0] mem_wdata_o,
    output reg [1:0] mem_be_o,
    output reg mem_we_o,
    output reg mem_re_o,
    input wire [`PSB_DW-1:0] mem_rdata_i,
    input wire [1:0] reg_addr_i,
    input wire [`PSB_DW-1:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [`PSB_DW-1:0] reg_rdata_o
);

// ------------------------------------------------------------
// State encoding
// ------------------------------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_ASYNC = 2'b01;
localparam ST_BLAT = 2'b10;
localparam ST_BDAT = 2'b11;

// ------------------------------------------------------------
// Pin synchronisation
// ------------------------------------------------------------
wire [`PSB_SYNC_W-1:0] s_vec;
wire [`PSB_AHI_W-1:0] s_ahi;
wire [`PSB_DW-1:0] s_ad;
wire s_clk;
wire s_adv_n;
wire s_cs_n;
wire s_oe_n;
wire s_we_n;
wire s_cre;
wire s_lb_n;
wire s_ub_n;

psb_sync #(
    .W(`PSB_SYNC_W),
    .RST_VAL(`PSB_SYNC_RST)
) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i({addr_hi_i, ad_i, link_clk_i, addr_valid_n_i, chip_sel_n_i, out_en_n_i,
            wr_en_n_i, cfg_reg_sel_i, low_byte_en_n_i, high_byte_en_n_i}),
    .val_o(s_vec)
);

assign {s_ahi, s_ad, s_clk, s_adv_n, s_cs_n, s_oe_n, s_we_n, s_cre, s_lb_n, s_ub_n} = s_vec;

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg [1:0] state;
reg [`PSB_INIT_W-1:0] init_cnt;
reg init_done;
reg p_clk;
reg p_adv_n;
reg p_cs_n;
reg p_we_n;
reg p_lb_n;
reg p_ub_n;
reg [`PSB_AW-1:0] addr;
reg op_wr;
reg op_cfg;
reg clk_seen;
reg wpend;
reg [`PSB_DW-1:0] wdat;
reg [1:0] wbe;
reg rd_wait;
reg [`PSB_DW-1:0] rd_word;
reg [`PSB_LAT_W-1:0] lat;
reg [`PSB_LAT_W-1:0] lat_cnt;
reg cfg_we;
reg [1:0] cfg_sel;
reg [`PSB_DW-1:0] cfg_wdata;

wire [`PSB_DW-1:0] bus_cfg_reg;
wire [`PSB_DW-1:0] refresh_cfg_reg;
wire [`PSB_DW-1:0] cfg_rdata;

// ------------------------------------------------------------
// Decoded pin events
// ------------------------------------------------------------
wire [31:0] init_cnt_x = {20'h00000, init_cnt};
wire mode_async = bus_cfg_reg[`PSB_BCR_MODE];
wire clk_rise = s_clk & ~p_clk;
wire adv_rise = s_adv_n & ~p_adv_n;
wire ctl_rise = (s_cs_n & ~p_cs_n) | (s_we_n & ~p_we_n) |
                (s_lb_n & ~p_lb_n) | (s_ub_n & ~p_ub_n);
wire [`PSB_AW-1:0] pin_addr = {s_ahi, s_ad};
wire [1:0] lanes = {~s_ub_n, ~s_lb_n};
wire [`PSB_AW-1:0] addr_inc = addr + {{(`PSB_AW-1){1'b0}}, 1'b1};
wire burst_start = ~mode_async & clk_rise & ~s_adv_n & ~s_cs_n;
wire async_start = adv_rise & ~s_cs_n & (mode_async | ~clk_seen);
wire reading = ~op_wr & ((state == ST_ASYNC) | (state == ST_BDAT));

// ------------------------------------------------------------
// Configuration registers
// ------------------------------------------------------------
psb_cfg_regs u_cfg (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(cfg_we),
    .sel_i(cfg_sel),
    .wdata_i(cfg_wdata),
    .bus_cfg_reg_o(bus_cfg_reg),
    .refresh_cfg_reg_o(refresh_cfg_reg),
    .rdata_o(cfg_rdata)
);

// ------------------------------------------------------------
// Bus sequencing
// ------------------------------------------------------------
always @(posedge core_clk_i) begin
    if (rst_i) begin
        state <= ST_IDLE;
        init_cnt <= {`PSB_INIT_W{1'b0}};
        init_done <= 1'b0;
        p_clk <= 1'b0;
        p_adv_n <= 1'b1;
        p_cs_n <= 1'b1;
        p_we_n <= 1'b1;
        p_lb_n <= 1'b1;
        p_ub_n <= 1'b1;
        addr <= {`PSB_AW{1'b0}};
        op_wr <= 1'b0;
        op_cfg <= 1'b0;
        clk_seen <= 1'b0;
        wpend <= 1'b0;
        wdat <= {`PSB_DW{1'b0}};
        wbe <= 2'b00;
        rd_wait <= 1'b0;
        rd_word <= {`PSB_DW{1'b0}};
        lat_cnt <= {`PSB_LAT_W{1'b0}};
        cfg_we <= 1'b0;
        cfg_sel <= `PSB_SEL_RCR;
        cfg_wdata <= {`PSB_DW{1'b0}};
        mem_addr_o <= {`PSB_AW{1'b0}};
        mem_wdata_o <= {`PSB_DW{1'b0}};
        mem_be_o <= 2'b00;
        mem_we_o <= 1'b0;
        mem_re_o <= 1'b0;
    end else if (ce_i) begin
        p_clk <= s_clk;
        p_adv_n <= s_adv_n;
        p_cs_n <= s_cs_n;
        p_we_n <= s_we_n;
        p_lb_n <= s_lb_n;
        p_ub_n <= s_ub_n;
        mem_we_o <= 1'b0;
        mem_re_o <= 1'b0;
        cfg_we <= 1'b0;
        rd_wait <= mem_re_o;
        if (rd_wait) begin
            rd_word <= mem_rdata_i;
        end
        if (!init_done) begin
            init_cnt <= init_cnt + {{(`PSB_INIT_W-1){1'b0}}, 1'b1};
            if (init_cnt_x == `PSB_INIT_CYC - 1) begin
                init_done <= 1'b1;
            end
        end else begin
            // Async write data follows the bus until the first closing edge
            if (wpend) begin
                if (ctl_rise) begin
                    wpend <= 1'b0;
                    mem_addr_o <= addr;
                    mem_wdata_o <= wdat;
                    mem_be_o <= wbe;
                    mem_we_o <= |wbe;
                end else begin
                    wdat <= s_ad;
                    wbe <= lanes;
                end
            end
            if (s_cs_n) begin
                state <= ST_IDLE;
                clk_seen <= 1'b0;
            end else if (burst_start) begin
                addr <= pin_addr;
                op_wr <= ~s_we_n;
                op_cfg <= s_cre;
                clk_seen <= 1'b1;
                lat_cnt <= lat;
                state <= ST_BLAT;
                cfg_sel <= s_ahi[`PSB_SEL_HI-`PSB_DW:`PSB_SEL_LO-`PSB_DW];
                if (s_cre) begin
                    cfg_we <= ~s_we_n;
                    cfg_wdata <= s_ad;
                end else if (s_we_n) begin
                    mem_addr_o <= pin_addr;
                    mem_re_o <= 1'b1;
                end
            end else if (!s_adv_n && state != ST_BLAT && state != ST_BDAT) begin
                addr <= pin_addr;
                op_wr <= ~s_we_n;
                op_cfg <= s_cre;
                cfg_sel <= s_ahi[`PSB_SEL_HI-`PSB_DW:`PSB_SEL_LO-`PSB_DW];
                cfg_wdata <= s_ad;
                if (clk_rise) begin
                    clk_seen <= 1'b1;
                end
            end else if (async_start) begin
                state <= ST_ASYNC;
                if (op_cfg) begin
                    cfg_we <= op_wr;
                end else if (op_wr) begin
                    wpend <= 1'b1;
                    wdat <= s_ad;
                    wbe <= lanes;
                end else begin
                    mem_addr_o <= addr;
                    mem_re_o <= 1'b1;
                end
            end else if (state == ST_BLAT && clk_rise) begin
                if (lat_cnt <= `PSB_LAT_ONE) begin
                    state <= ST_BDAT;
                end else begin
                    lat_cnt <= lat_cnt - `PSB_LAT_ONE;
                end
            end else if (state == ST_BDAT && clk_rise && s_adv_n) begin
                addr <= addr_inc;
                if (op_cfg) begin
                    state <= ST_IDLE;
                end else if (op_wr) begin
                    mem_addr_o <= addr;
                    mem_wdata_o <= s_ad;
                    mem_be_o <= lanes;
                    mem_we_o <= |lanes;
                end else begin
                    mem_addr_o <= addr_inc;
                    mem_re_o <= 1'b1;
                end
            end else begin
                // Anything else with chip select low is a no-op
                state <= state;
            end
        end
    end
end

// ------------------------------------------------------------
// Pin drivers
// ------------------------------------------------------------
always @(posedge core_clk_i) begin
    if (rst_i) begin
        ad_o <= {`PSB_DW{1'b0}};
        ad_oe_o <= {`PSB_DW{1'b0}};
        wait_o <= 1'b0;
        wait_oe_o <= 1'b0;
    end else if (ce_i) begin
        ad_o <= op_cfg ? cfg_rdata : rd_word;
        if (s_cs_n || !init_done || !reading || s_oe_n || !s_adv_n) begin
            ad_oe_o <= {`PSB_DW{1'b0}};
        end else begin
            ad_oe_o <= {{(`PSB_DW/2){lanes[1]}}, {(`PSB_DW/2){lanes[0]}}};
        end
        wait_oe_o <= ~s_cs_n & init_done;
        // Wait active except while burst data flows
        if (bus_cfg_reg[`PSB_BCR_WPOL]) begin
            wait_o <= (state != ST_BDAT);
        end else begin
            wait_o <= (state == ST_BDAT);
        end
    end
end

// ------------------------------------------------------------
// Software register port
// ------------------------------------------------------------
always @(posedge core_clk_i) begin
    if (rst_i) begin
        lat <= `PSB_LAT_RST;
        reg_rdata_o <= {`PSB_DW{1'b0}};
    end else if (ce_i) begin
        if (reg_we_i && reg_addr_i == `PSB_RA_LAT) begin
            lat <= reg_wdata_i[`PSB_LAT_W-1:0];
        end
        reg_rdata_o <= {`PSB_DW{1'b0}};
        if (reg_re_i) begin
            case (reg_addr_i)
                `PSB_RA_STAT: reg_rdata_o <= {11'h000, wpend, state, mode_async, init_done};
                `PSB_RA_BCR: reg_rdata_o <= bus_cfg_reg;
                `PSB_RA_RCR: reg_rdata_o <= refresh_cfg_reg;
                `PSB_RA_LAT: reg_rdata_o <= {13'h0000, lat};
                default: reg_rdata_o <= {`PSB_DW{1'b0}};
            endcase
        end
    end
end

endmodule // psb_bus_if

/* File: tb/psb_bus_if_checker.sv */
`timescale 1ns/100ps
`include "psb_defs.vh"
module psb_bus_if_checker (
    input wire core_clk_i,
    input wire rst_i,
    input wire chip_sel_n_i,
    input wire out_en_n_i,
    input wire addr_valid_n_i,
    input wire reg_re_i,
    input wire [`PSB_DW-1:0] ad_oe_o,
    input wire wait_o,
    input wire wait_oe_o,
    input wire mem_we_o,
    input wire mem_re_o,
    input wire [1:0] mem_be_o,
    input wire [`PSB_DW-1:0] reg_rdata_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Cycles since reset release
    // ------------------------------------------------------------
    reg [`PSB_INIT_W-1:0] init_cnt;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            init_cnt <= {`PSB_INIT_W{1'b0}};
        end else if (init_cnt != `PSB_INIT_CYC) begin
            init_cnt <= init_cnt + 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_clear_a: assert property ($past(rst_i) |-> !wait_oe_o && ad_oe_o == 16'h0000 && !mem_we_o)
        else $error("outputs not cleared by reset");
    init_quiet_a: assert property ((init_cnt < `PSB_INIT_CYC) |-> !wait_oe_o && !mem_we_o && !mem_re_o)
        else $error("activity during self init");
    standby_release_a: assert property (chip_sel_n_i [*8] |-> ad_oe_o == 16'h0000 && !wait_oe_o)
        else $error("pins driven in standby");
    standby_idle_a: assert property (chip_sel_n_i [*8] |=> !mem_we_o && !mem_re_o)
        else $error("memory access in standby");
    suspend_release_a: assert property (out_en_n_i [*8] |-> ad_oe_o == 16'h0000)
        else $error("bus driven with out_en high");
    addr_phase_a: assert property (!addr_valid_n_i [*8] |-> ad_oe_o == 16'h0000)
        else $error("bus driven in address phase");
    lane_shape_a: assert property ((ad_oe_o[7:0] == 8'h00 || ad_oe_o[7:0] == 8'hFF) && (ad_oe_o[15:8] == 8'h00 || ad_oe_o[15:8] == 8'hFF))
        else $error("bus enable not whole lanes");
    write_lanes_a: assert property (mem_we_o |-> mem_be_o != 2'h0)
        else $error("write with no lane");
    strobe_pulse_a: assert property ((mem_we_o || mem_re_o) |=> !mem_we_o && !mem_re_o)
        else $error("memory strobe too long");
    rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    cover property (wait_oe_o && wait_o);
    cover property (mem_we_o);
    cover property (mem_re_o);
endmodule // psb_bus_if_checker
bind psb_bus_if psb_bus_if_checker chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .chip_sel_n_i(chip_sel_n_i),
    .out_en_n_i(out_en_n_i), .addr_valid_n_i(addr_valid_n_i), .reg_re_i(reg_re_i), .ad_oe_o(ad_oe_o),
    .wait_o(wait_o), .wait_oe_o(wait_oe_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_be_o(mem_be_o),
    .reg_rdata_o(reg_rdata_o));

/* File: tb/psb_ctl_model.sv */
`timescale 1ns/100ps
module psb_ctl_model (
    input wire core_clk_i,
    input wire [15:0] ad_i,
    input wire wait_i,
    output reg link_clk_o,
    output reg addr_valid_n_o,
    output reg chip_sel_n_o,
    output reg out_en_n_o,
    output reg wr_en_n_o,
    output reg cfg_reg_sel_o,
    output reg [1:0] be_n_o,
    output reg [7:0] addr_hi_o,
    output reg [15:0] ad_o
);
    initial begin
        link_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        addr_valid_n_o = 1'b1;
        out_en_n_o = 1'b1;
        wr_en_n_o = 1'b1;
        cfg_reg_sel_o = 1'b0;
        be_n_o = 2'h3;
        addr_hi_o = 8'h00;
        ad_o = 16'h0000;
    end
    task step(input integer n);
        begin
            repeat (n) @(posedge core_clk_i);
        end
    endtask
    task pulse;
        begin
            link_clk_o <= 1'b1;
            step(4);
            link_clk_o <= 1'b0;
            step(4);
        end
    endtask
    task start(input w, input c, input [23:0] a, input [1:0] be);
        begin
            step(1);
            chip_sel_n_o <= 1'b0;
            addr_valid_n_o <= 1'b0;
            wr_en_n_o <= !w;
            out_en_n_o <= 1'b1;
            cfg_reg_sel_o <= c;
            be_n_o <= be;
            addr_hi_o <= a[23:16];
            ad_o <= a[15:0];
            step(8);
        end
    endtask
    task finish;
        begin
            chip_sel_n_o <= 1'b1;
            wr_en_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            be_n_o <= 2'h3;
            cfg_reg_sel_o <= 1'b0;
            ad_o <= ~ad_o;
            step(8);
        end
    endtask
    // Async access, link clock parked throughout
    task async_op(input c, input w, input [23:0] a, input [15:0] d, input [1:0] be, output [15:0] rd);
        begin
            start(w, c, a, be);
            addr_valid_n_o <= 1'b1;
            out_en_n_o <= w;
            ad_o <= w ? d : ~a[15:0];
            step(8);
            wr_en_n_o <= 1'b1;
            step(8);
            rd = ad_i;
            finish;
        end
    endtask
    // Two-word burst, write or read; returns wait level, latency and words seen
    task burst_op(input w, input [23:0] a, input [15:0] d0, input [15:0] d1, output w0, output [15:0] lat,
        output [15:0] r0, output [15:0] r1);
        integer i;
        begin
            start(w, 1'b0, a, 2'h0);
            pulse;
            addr_valid_n_o <= 1'b1;
            out_en_n_o <= w;
            ad_o <= w ? d0 : ~a[15:0];
            step(8);
            w0 = wait_i;
            lat = 16'h0000;
            for (i = 0; i < 8 && wait_i; i = i + 1) begin
                pulse;
                lat = lat + 16'h0001;
            end
            r0 = ad_i;
            pulse;
            ad_o <= w ? d1 : ~a[15:0];
            step(4);
            r1 = ad_i;
            pulse;
            finish;
        end
    endtask
endmodule // psb_ctl_model

/* File: tb/test_psb_bus_if.sv */
`timescale 1ns/100ps
`include "psb_defs.vh"
module test_psb_bus_if;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [1:0] reg_addr_i = 2'h0;
    reg [15:0] reg_wdata_i = 16'h0000;
    reg reg_we_i = 1'b0;
    reg reg_re_i = 1'b0;
    reg [15:0] mem_rdata_i = 16'h0000;
    reg [15:0] mem [0:15];
    integer num_errors = 0;
    integer checks = 0;
    integer cycles = 0;
    integer i;
    reg [15:0] v;
    reg [15:0] e;
    reg [15:0] lat;
    reg w0;
    wire link_clk, av_n, cs_n, oe_n, we_n, cfg_reg_sel, wait_s, wait_oe;
    wire [1:0] be_n;
    wire [7:0] ahi;
    wire [15:0] ctl_ad, dut_ad, ad_oe, mem_wdata;
    wire [23:0] mem_addr;
    wire [1:0] mem_be;
    wire mem_we, mem_re;
    wire [15:0] reg_rdata;
    wire [15:0] ad_pin = (ad_oe & dut_ad) | (~ad_oe & ctl_ad);
    always #25 core_clk_i = ~core_clk_i;
    psb_ctl_model ctl (.core_clk_i(core_clk_i), .ad_i(ad_pin), .wait_i(wait_s), .link_clk_o(link_clk),
        .addr_valid_n_o(av_n), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .wr_en_n_o(we_n), .cfg_reg_sel_o(cfg_reg_sel),
        .be_n_o(be_n), .addr_hi_o(ahi), .ad_o(ctl_ad));
    psb_bus_if dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .link_clk_i(link_clk),
        .addr_valid_n_i(av_n), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n), .cfg_reg_sel_i(cfg_reg_sel),
        .low_byte_en_n_i(be_n[0]), .high_byte_en_n_i(be_n[1]), .addr_hi_i(ahi), .ad_i(ad_pin), .ad_o(dut_ad),
        .ad_oe_o(ad_oe), .wait_o(wait_s), .wait_oe_o(wait_oe), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
        .mem_be_o(mem_be), .mem_we_o(mem_we), .mem_re_o(mem_re), .mem_rdata_i(mem_rdata_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata));
    // ------------------------------------------------------------
    // Memory array and timeout
    // ------------------------------------------------------------
    initial for (i = 0; i < 16; i = i + 1) mem[i] = 16'h0000;
    always @(posedge core_clk_i) begin
        if (mem_we && mem_be[0]) mem[mem_addr[3:0]][7:0] <= mem_wdata[7:0];
        if (mem_we && mem_be[1]) mem[mem_addr[3:0]][15:8] <= mem_wdata[15:8];
        if (mem_re) mem_rdata_i <= mem[mem_addr[3:0]];
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input [63:0] name, input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task reg_write(input [1:0] a, input [15:0] d);
        begin
            @(posedge core_clk_i);
            reg_we_i <= 1'b1;
            reg_addr_i <= a;
            reg_wdata_i <= d;
            @(posedge core_clk_i);
            reg_we_i <= 1'b0;
        end
    endtask
    task reg_read(input [1:0] a, output [15:0] d);
        begin
            @(posedge core_clk_i);
            reg_re_i <= 1'b1;
            reg_addr_i <= a;
            @(posedge core_clk_i);
            reg_re_i <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d num_errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        reg_read(2'h0, v);
        check("status", v & 16'h0003, 16'h0002);
        reg_read(2'h1, v);
        check("buscfg", v, `PSB_BCR_RST);
        reg_read(2'h2, v);
        check("refcfg", v, `PSB_RCR_RST);
        reg_write(2'h1, 16'h1234);
        reg_write(2'h3, 16'h0002);
        reg_read(2'h1, v);
        check("buscfg", v, `PSB_BCR_RST);
        reg_read(2'h3, v);
        check("latency", v & 16'h0007, 16'h0002);
        ctl.step(3000);
        reg_read(2'h0, v);
        check("status", v & 16'h0003, 16'h0003);
        $display("test reset and init done");
        e = 16'h0000;
        for (i = 0; i < 3; i = i + 1) begin
            v = (i == 0) ? 16'hAAAA : (i == 1) ? 16'h1155 : 16'h66BB;
            e = (i == 0) ? v : (i == 1) ? {e[15:8], v[7:0]} : {v[15:8], e[7:0]};
            ctl.async_op(1'b0, 1'b1, 24'h000001, v, (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h1, v);
            ctl.async_op(1'b0, 1'b0, 24'h000001, 16'h0000, 2'h0, v);
            check("lanes", v, e);
        end
        $display("test async lanes done");
        ctl.async_op(1'b1, 1'b0, 24'h040000, 16'h0000, 2'h0, v);
        check("ident", v, `PSB_ID_VAL);
        ctl.async_op(1'b1, 1'b1, 24'h080400, 16'h0000, 2'h0, v);
        reg_read(2'h1, v);
        check("buscfg", v, 16'h0400);
        reg_read(2'h0, v);
        check("status", v & 16'h0003, 16'h0001);
        $display("test config access done");
        ctl.burst_op(1'b1, 24'h000004, 16'hC3C3, 16'h3C3C, w0, lat, v, e);
        check("waitpol", {15'h0, w0}, 16'h0001);
        check("latency", lat, 16'h0002);
        check("release", ad_oe | {15'h0, wait_oe}, 16'h0000);
        ctl.async_op(1'b0, 1'b0, 24'h000004, 16'h0000, 2'h0, v);
        check("burst0", v, 16'hC3C3);
        ctl.async_op(1'b0, 1'b0, 24'h000005, 16'h0000, 2'h0, v);
        check("burst1", v, 16'h3C3C);
        $display("test burst write done");
        ctl.burst_op(1'b0, 24'h000004, 16'h0000, 16'h0000, w0, lat, v, e);
        check("bread0", v, 16'hC3C3);
        check("bread1", e, 16'h3C3C);
        check("rdlat", lat, 16'h0002);
        $display("test burst read done");
        rst_i <= 1'b1;
        ctl.step(3);
        rst_i <= 1'b0;
        reg_read(2'h1, v);
        check("buscfg", v, `PSB_BCR_RST);
        $display("test second reset done");
        stop_test;
    end
endmodule // test_psb_bus_if
